// *** inc/eik_consts.vh ***
// Constants for the external interrupt and key-sense front end.
// Assumes inclusion by bare name from the rtl files; definitions only.
`ifndef EIK_CONSTS_VH
`define EIK_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EIK_OFS_SENSE    8'h00
`define EIK_OFS_ENABLE   8'h04
`define EIK_OFS_KEYMASK  8'h08
`define EIK_OFS_SYSCTL   8'h0C
`define EIK_OFS_PENDING  8'h10
`define EIK_OFS_STATUS   8'h14

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define EIK_RST_SENSE    8'h00
`define EIK_RST_ENABLE   8'h00
`define EIK_RST_KEYMASK  8'hBF
`define EIK_RST_SYSCTL   8'h00
`define EIK_SYS_NMIEDGE  2
`define EIK_KEY_SHARED   6
`define EIK_ST_REQ       0
`define EIK_ST_NMI       1
`define EIK_ST_VEC_LO    2

// ----------------------------------------------------------------
// Vectors and wake-up sources
// ----------------------------------------------------------------
`define EIK_VEC_NMI      6'h03
`define EIK_VEC_BASE     6'h04
`define EIK_WAKE_LINES   8'h47

// ----------------------------------------------------------------
// AHB encodings
// ----------------------------------------------------------------
`define EIK_HTRANS_NSEQ  2'h2
`define EIK_HRESP_OKAY   1'h0

`endif

// *** rtl/eik_line.v ***
// One maskable request line: sampling, edge detection, pending latch.
// Assumes the input is synchronous to clk; the ack is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

module eik_line (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Pin and controls
  input  wire in_n,
  input  wire sense_edge,
  input  wire enable,
  input  wire gmask,
  input  wire service,
  // Request out
  output wire req
);

  reg cur_n;
  reg prev_n;
  reg pend;
  wire fall;

  // ----------------------------------------------------------------
  // Sampling and edge detect
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      cur_n  <= 1'b1;
      prev_n <= 1'b1;
    end else begin
      cur_n  <= in_n;
      prev_n <= cur_n;
    end
  end

  assign fall = prev_n & ~cur_n;

  // ----------------------------------------------------------------
  // Pending latch: set wins over every clear
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pend <= 1'b0;
    end else if (sense_edge & fall & enable) begin
      pend <= 1'b1;
    end else if (service | (gmask & ~sense_edge & ~enable)) begin
      pend <= 1'b0;
    end
  end

  // Level mode follows the sample; a pending edge survives a cleared enable
  assign req = sense_edge ? pend : (~cur_n & enable);

endmodule // eik_line
`default_nettype wire

// *** rtl/eik_prio.v ***
// Fixed-priority pick among the maskable requests, line 0 highest.
// Assumes purely combinational use by the top.
`timescale 1ns/1ps
`default_nettype none

module eik_prio #(
  parameter N = 8
) (
  // Requests
  input  wire [N-1:0] req,
  // Winner
  output wire         any,
  output wire [2:0]   idx
);

  // Lowest set index wins
  function [2:0] first_set;
    input [N-1:0] v;
    integer i;
    begin
      first_set = 3'h0;
      for (i = N - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[2:0];
        end
      end
    end
  endfunction

  assign any = |req;
  assign idx = first_set(req);

endmodule // eik_prio
`default_nettype wire

// *** rtl/eik_top.v ***
// External interrupt front end: eight maskable lines, key-sense merge, NMI.
// Assumes an AHB-Lite master, a CPU that supplies its mask bit and acks
// the presented vector with a one-cycle pulse, and inputs synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "eik_consts.vh"

module eik_top #(
  parameter NLINE  = 8,
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              rst,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  // External pins (pad levels, direction not relevant)
  input  wire [NLINE-1:0]  irq_in_n,
  input  wire [7:0]        key_in_n,
  input  wire              nmi_in_n,
  // CPU side
  input  wire              cpu_mask,
  input  wire              cpu_ack,
  input  wire              standby,
  output reg               int_req,
  output reg  [5:0]        int_vector,
  output reg               mask_set,
  output reg               wake_up
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [7:0]        irq_sense_select;
  reg  [7:0]        irq_line_enable;
  reg  [7:0]        key_sense_mask;
  reg  [7:0]        system_control_reg;
  reg  [7:0]        next_sense;
  reg  [7:0]        next_enable;
  reg  [7:0]        next_keymask;
  reg  [7:0]        next_sysctl;
  reg               wr_pend;
  reg  [ADDR_W-1:0] wr_addr;
  reg  [31:0]       next_rdata;
  reg               nmi_cur_n;
  reg               nmi_prev_n;
  reg               nmi_pend;
  reg  [5:0]        next_vector;
  reg               next_req;
  wire              addr_ok;
  reg  [7:0]        key_vec_n;
  wire              shared_pad_n;
  wire              line6_n;
  wire [NLINE-1:0]  line_n;
  wire [NLINE-1:0]  line_req;
  wire [NLINE-1:0]  accepted;
  wire [NLINE-1:0]  service;
  wire              win_any;
  wire [2:0]        win_idx;
  wire              nmi_edge;
  wire              ack_nmi;
  wire              ack_line;
  wire [2:0]        ack_idx;
  wire [5:0]        ack_off;
  wire              ack_any;
  wire              wake_src;

  // Register select by byte offset
  function sel;
    input [ADDR_W-1:0] a;
    input [7:0]        ofs;
    begin
      sel = (a[7:0] == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // AHB address phase capture
  // ----------------------------------------------------------------
  // Zero wait states; the slave never stalls the bus
  // hsize is not decoded: only whole-word transfers are supported
  assign addr_ok = hsel & hready & (htrans == `EIK_HTRANS_NSEQ);

  always @(posedge mclk) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= {ADDR_W{1'b0}};
      hreadyout <= 1'b1;
      hresp     <= `EIK_HRESP_OKAY;
    end else begin
      wr_pend   <= addr_ok & hwrite;
      hreadyout <= 1'b1;
      hresp     <= `EIK_HRESP_OKAY;
      if (addr_ok) begin
        wr_addr <= haddr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register write in the data phase
  // ----------------------------------------------------------------
  always @* begin
    next_sense   = irq_sense_select;
    next_enable  = irq_line_enable;
    next_keymask = key_sense_mask;
    next_sysctl  = system_control_reg;
    if (wr_pend) begin
      if (sel(wr_addr, `EIK_OFS_SENSE)) begin
        next_sense = hwdata[7:0];
      end
      if (sel(wr_addr, `EIK_OFS_ENABLE)) begin
        next_enable = hwdata[7:0];
      end
      if (sel(wr_addr, `EIK_OFS_KEYMASK)) begin
        next_keymask = hwdata[7:0];
      end
      if (sel(wr_addr, `EIK_OFS_SYSCTL)) begin
        // Only the NMI edge bit is writable
        next_sysctl = hwdata[7:0] & (8'h01 << `EIK_SYS_NMIEDGE);
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      irq_sense_select   <= `EIK_RST_SENSE;
      irq_line_enable    <= `EIK_RST_ENABLE;
      key_sense_mask     <= `EIK_RST_KEYMASK;
      system_control_reg <= `EIK_RST_SYSCTL;
    end else begin
      irq_sense_select   <= next_sense;
      irq_line_enable    <= next_enable;
      key_sense_mask     <= next_keymask;
      system_control_reg <= next_sysctl;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered for the data phase
  // ----------------------------------------------------------------
  // Reads use the post-write values so a read right after a write sees it
  always @* begin
    next_rdata = 32'h0000_0000;
    if (sel(haddr, `EIK_OFS_SENSE)) begin
      next_rdata[7:0] = next_sense;
    end else if (sel(haddr, `EIK_OFS_ENABLE)) begin
      next_rdata[7:0] = next_enable;
    end else if (sel(haddr, `EIK_OFS_KEYMASK)) begin
      next_rdata[7:0] = next_keymask;
    end else if (sel(haddr, `EIK_OFS_SYSCTL)) begin
      next_rdata[7:0] = next_sysctl;
    end else if (sel(haddr, `EIK_OFS_PENDING)) begin
      next_rdata[NLINE-1:0] = line_req;
    end else if (sel(haddr, `EIK_OFS_STATUS)) begin
      // Request flag, NMI pending, shown vector
      next_rdata[`EIK_ST_REQ]             = int_req;
      next_rdata[`EIK_ST_NMI]             = nmi_pend;
      next_rdata[`EIK_ST_VEC_LO+5:`EIK_ST_VEC_LO] = int_vector;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Key-sense merge onto line 6
  // ----------------------------------------------------------------
  // Key bit 6 and request pin 6 are one pad, seen through the key mask
  assign shared_pad_n = key_in_n[`EIK_KEY_SHARED] & irq_in_n[`EIK_KEY_SHARED];

  always @* begin
    key_vec_n                  = key_in_n;
    key_vec_n[`EIK_KEY_SHARED] = shared_pad_n;
  end
  // Active low: any key input low with mask bit zero pulls line 6 low
  assign line6_n   = &(key_vec_n | key_sense_mask);

  genvar g;
  generate
    for (g = 0; g < NLINE; g = g + 1) begin : g_line
      if (g == `EIK_KEY_SHARED) begin : g_key
        assign line_n[g] = line6_n;
      end else begin : g_pin
        // Pad level is sampled whatever the port direction
        assign line_n[g] = irq_in_n[g];
      end
      eik_line u_line (
        .clk        (mclk),
        .rst        (rst),
        .in_n       (line_n[g]),
        .sense_edge (irq_sense_select[g]),
        .enable     (irq_line_enable[g]),
        .gmask      (cpu_mask),
        .service    (service[g]),
        .req        (line_req[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Global mask and priority
  // ----------------------------------------------------------------
  // Latches stay set while masked, except on disabled level-mode lines; only forwarding is blocked
  assign accepted = line_req & {NLINE{~cpu_mask}};

  eik_prio #(
    .N (NLINE)
  ) u_prio (
    .req (accepted),
    .any (win_any),
    .idx (win_idx)
  );

  // ----------------------------------------------------------------
  // NMI edge detect
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      nmi_cur_n  <= 1'b1;
      nmi_prev_n <= 1'b1;
    end else begin
      nmi_cur_n  <= nmi_in_n;
      nmi_prev_n <= nmi_cur_n;
    end
  end

  assign nmi_edge = system_control_reg[`EIK_SYS_NMIEDGE] ?
                    (~nmi_prev_n & nmi_cur_n) :
                    (nmi_prev_n & ~nmi_cur_n);

  // ----------------------------------------------------------------
  // Acknowledge decode
  // ----------------------------------------------------------------
  // The ack applies to the vector shown in the same cycle
  assign ack_nmi  = cpu_ack & int_req & (int_vector == `EIK_VEC_NMI);
  assign ack_line = cpu_ack & int_req & (int_vector != `EIK_VEC_NMI);
  assign ack_any  = ack_nmi | ack_line;
  assign ack_off  = int_vector - `EIK_VEC_BASE;
  assign ack_idx  = ack_off[2:0];
  assign service  = {NLINE{ack_line}} & ({{(NLINE-1){1'b0}}, 1'b1} << ack_idx);

  // NMI ignores the global mask entirely; a new edge wins over the ack
  always @(posedge mclk) begin
    if (rst) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (ack_nmi) begin
      nmi_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Request and vector to the CPU
  // ----------------------------------------------------------------
  always @* begin
    next_req    = 1'b0;
    next_vector = 6'h00;
    if (ack_any) begin
      // Nothing shown in the cycle after an ack
      next_req    = 1'b0;
    end else if (nmi_pend) begin
      next_req    = 1'b1;
      next_vector = `EIK_VEC_NMI;
    end else if (win_any) begin
      next_req    = 1'b1;
      next_vector = `EIK_VEC_BASE + {3'h0, win_idx};
    end
  end

  // One idle cycle after each ack lets the serviced latch clear first
  // A level line may show again until the CPU has raised its mask
  always @(posedge mclk) begin
    if (rst) begin
      int_req    <= 1'b0;
      int_vector <= 6'h00;
      mask_set   <= 1'b0;
    end else begin
      int_req    <= next_req;
      int_vector <= next_vector;
      mask_set   <= ack_any;
    end
  end

  // ----------------------------------------------------------------
  // Standby wake-up
  // ----------------------------------------------------------------
  // NMI and enabled requests on the wake lines count; the mask does not
  assign wake_src = nmi_edge | nmi_pend | (|(line_req & `EIK_WAKE_LINES));

  always @(posedge mclk) begin
    if (rst) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= standby & wake_src;
    end
  end

endmodule // eik_top
`default_nettype wire

// *** testbench/eik_top_asserts.sv ***
// Checker for the CPU and bus answer ports of eik_top.
// Assumes a bind from the bench; sees top ports only.
`timescale 1ns/1ps
`default_nettype none
module eik_top_asserts (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Bus answer
  input wire logic       hreadyout,
  input wire logic       hresp,
  // CPU side
  input wire logic       cpu_mask,
  input wire logic       cpu_ack,
  input wire logic       standby,
  input wire logic       int_req,
  input wire logic [5:0] int_vector,
  input wire logic       mask_set,
  input wire logic       wake_up
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  vec_range_a: assert property (int_req |-> int_vector == 6'h03 ||
    (int_vector >= 6'h04 && int_vector <= 6'h0B)) else $error("vector out of range");
  ack_mask_a: assert property (cpu_ack && int_req |=> mask_set && !int_req)
    else $error("ack not followed by mask pulse");
  mask_cause_a: assert property (mask_set |-> $past(cpu_ack))
    else $error("mask pulse without ack");
  mask_once_a: assert property (mask_set |=> !mask_set)
    else $error("mask pulse too long");
  gmask_block_a: assert property (cpu_mask [*3] |-> !int_req || int_vector == 6'h03)
    else $error("line request passed global mask");
  wake_gate_a: assert property (!standby [*2] |-> !wake_up)
    else $error("wake outside standby");
  rst_quiet_a: assert property ($past(rst) |-> !int_req && !mask_set && !wake_up)
    else $error("request right after reset");
  cover property (cpu_ack && int_vector == 6'h03);
  cover property (cpu_ack && int_vector == 6'h06);
  cover property (wake_up);
endmodule // eik_top_asserts
`default_nettype wire

// *** testbench/eik_cpu_model.sv ***
// Behavioural CPU core: holds the mask bit, acks shown requests.
// Assumes bench pulses sw_set/sw_clr as software mask writes.
`timescale 1ns/1ps
`default_nettype none
module eik_cpu_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // From controller
  input  wire logic       int_req,
  input  wire logic [5:0] int_vector,
  input  wire logic       mask_set,
  // Bench controls
  input  wire logic       ack_en,
  input  wire logic       sw_set,
  input  wire logic       sw_clr,
  input  wire logic [3:0] lag,
  // To controller and bench
  output logic            cpu_ack,
  output logic            cpu_mask,
  output logic [5:0]      got_vec
);
  logic [3:0] cnt;
  always @(posedge mclk) begin
    if (rst) begin
      cpu_ack  <= 1'b0;
      cpu_mask <= 1'b0;
      cnt      <= 4'h0;
      got_vec  <= 6'h00;
    end else begin
      cpu_ack <= 1'b0;
      if (mask_set || sw_set) cpu_mask <= 1'b1;
      else if (sw_clr) cpu_mask <= 1'b0;
      // Slow answer when lag is nonzero
      if (ack_en && int_req && !cpu_ack && !mask_set) begin
        if (cnt >= lag) begin
          cpu_ack <= 1'b1;
          got_vec <= int_vector;
          cnt     <= 4'h0;
        end else cnt <= cnt + 4'h1;
      end else cnt <= 4'h0;
    end
  end
endmodule // eik_cpu_model
`default_nettype wire

// *** testbench/eik_top_test.sv ***
// Self-checking bench for eik_top with a CPU model.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "eik_consts.vh"
module eik_top_test;
  logic        mclk, rst, hsel, hwrite, cpu_ack, cpu_mask, standby, hresp;
  logic        nmi_in_n, ack_en, sw_set, sw_clr, int_req, mask_set, wake_up, hreadyout;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lag;
  logic [5:0]  int_vector, got_vec;
  logic [7:0]  haddr, irq_in_n, key_in_n;
  logic [31:0] hwdata, hrdata, rdv;
  int          n_mismatch, total_checks;
  eik_top u_eik_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_in_n(irq_in_n), .key_in_n(key_in_n),
    .nmi_in_n(nmi_in_n), .cpu_mask(cpu_mask), .cpu_ack(cpu_ack), .standby(standby),
    .int_req(int_req), .int_vector(int_vector), .mask_set(mask_set), .wake_up(wake_up));
  eik_cpu_model u_eik_cpu_model (.mclk(mclk), .rst(rst), .int_req(int_req),
    .int_vector(int_vector), .mask_set(mask_set), .ack_en(ack_en), .sw_set(sw_set),
    .sw_clr(sw_clr), .lag(lag), .cpu_ack(cpu_ack), .cpu_mask(cpu_mask), .got_vec(got_vec));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----
  // Shared tasks
  // ----
  task chk(input [31:0] s, input [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task rdy;
    int i;
    i = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      if (++i > 20) begin n_mismatch++; wrap_up; end
      @(posedge mclk);
    end
  endtask
  task xfer(input logic w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= `EIK_HTRANS_NSEQ; hwrite <= w;
    rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    rdy;
    rdv = hrdata;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task pin(input [7:0] v);
    @(posedge mclk) irq_in_n <= v;
  endtask
  task wreq(input [5:0] v);
    int i;
    for (i = 0; i < 12 && !(int_req === 1'b1 && int_vector === v); i++) @(posedge mclk);
    chk(int_req, 1); chk(int_vector, v);
  endtask
  task nreq;
    repeat (8) @(posedge mclk);
    chk(int_req, 0);
  endtask
  task wack(input [5:0] v);
    int i;
    ack_en <= 1'b1;
    for (i = 0; i < 20 && cpu_ack !== 1'b1; i++) @(posedge mclk);
    ack_en <= 1'b0;
    chk(cpu_ack, 1);
    chk(got_vec, v);
  endtask
  task msk(input logic s);
    @(posedge mclk) begin sw_set <= s; sw_clr <= !s; end
    @(posedge mclk) begin sw_set <= 1'b0; sw_clr <= 1'b0; end
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    rchk(`EIK_OFS_SENSE, 32'h0);
    rchk(`EIK_OFS_ENABLE, 32'h0);
    rchk(`EIK_OFS_KEYMASK, 32'hBF);
    rchk(`EIK_OFS_SYSCTL, 32'h0);
    xfer(1'b1, `EIK_OFS_ENABLE, 32'hA5);
    rchk(`EIK_OFS_ENABLE, 32'hA5);
    xfer(1'b1, 8'h1C, 32'hFF);
    rchk(8'h1C, 32'h0);
    xfer(1'b1, `EIK_OFS_ENABLE, 32'h0);
    $display("t_regs done");
  endtask
  task t_level_prio;
    int n;
    pin(8'hF7); nreq;
    xfer(1'b1, `EIK_OFS_ENABLE, 32'h08); wreq(6'h07);
    rchk(`EIK_OFS_PENDING, 32'h08);
    rchk(`EIK_OFS_STATUS, 32'h1D);
    pin(8'hFF); nreq;
    xfer(1'b1, `EIK_OFS_ENABLE, 32'hFF);
    for (n = 0; n < 8; n++) begin
      pin(~(8'hFF << n)); wreq(6'(4 + n));
    end
    pin(8'hFF); xfer(1'b1, `EIK_OFS_ENABLE, 32'h40);
    @(posedge mclk) key_in_n <= 8'hFB; nreq;
    xfer(1'b1, `EIK_OFS_KEYMASK, 32'hBB); wreq(6'h0A);
    @(posedge mclk) key_in_n <= 8'hFF;
    xfer(1'b1, `EIK_OFS_KEYMASK, 32'hBF); nreq;
    $display("t_level_prio done");
  endtask
  task t_edge;
    xfer(1'b1, `EIK_OFS_SENSE, 32'h04); xfer(1'b1, `EIK_OFS_ENABLE, 32'h04);
    pin(8'hFB); pin(8'hFF); wreq(6'h06);
    xfer(1'b1, `EIK_OFS_ENABLE, 32'h0); wreq(6'h06);
    wack(6'h06);
    @(posedge mclk);
    chk(int_req, 0);
    repeat (3) @(posedge mclk);
    chk(cpu_mask, 1); msk(1'b0);
    pin(8'hFB); pin(8'hFF); nreq;
    xfer(1'b1, `EIK_OFS_ENABLE, 32'h04); pin(8'hFB); pin(8'hFF); wreq(6'h06);
    msk(1'b1); xfer(1'b1, `EIK_OFS_ENABLE, 32'h0); nreq;
    xfer(1'b1, `EIK_OFS_SENSE, 32'h0); xfer(1'b1, `EIK_OFS_SENSE, 32'h04);
    msk(1'b0); nreq;
    xfer(1'b1, `EIK_OFS_SENSE, 32'h0);
    $display("t_edge done");
  endtask
  task t_nmi;
    msk(1'b1); pin(8'hF7); xfer(1'b1, `EIK_OFS_ENABLE, 32'h08); nreq;
    @(posedge mclk) nmi_in_n <= 1'b0; wreq(6'h03);
    rchk(`EIK_OFS_STATUS, 32'h0F);
    rchk(`EIK_OFS_PENDING, 32'h08);
    wack(6'h03);
    @(posedge mclk) nmi_in_n <= 1'b1; nreq;
    xfer(1'b1, `EIK_OFS_SYSCTL, 32'h04);
    @(posedge mclk) nmi_in_n <= 1'b0; nreq;
    @(posedge mclk) nmi_in_n <= 1'b1; wreq(6'h03);
    wack(6'h03);
    xfer(1'b1, `EIK_OFS_ENABLE, 32'h8A); msk(1'b1);
    @(posedge mclk) standby <= 1'b1;
    pin(8'h77); repeat (6) @(posedge mclk);
    chk(wake_up, 0);
    pin(8'h75); repeat (6) @(posedge mclk);
    chk(wake_up, 1);
    @(posedge mclk) standby <= 1'b0;
    pin(8'hFF); xfer(1'b1, `EIK_OFS_ENABLE, 32'h0); msk(1'b0);
    $display("t_nmi done");
  endtask
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; irq_in_n = 8'hFF; key_in_n = 8'hFF; nmi_in_n = 1'b1;
    standby = 1'b0; ack_en = 1'b0; sw_set = 1'b0; sw_clr = 1'b0; lag = 4'h2;
    n_mismatch = 0; total_checks = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_level_prio;
    t_edge;
    lag <= 4'h0;
    t_nmi;
    wrap_up;
  end
endmodule // eik_top_test
bind eik_top eik_top_asserts u_eik_top_asserts (.mclk(mclk), .rst(rst), .hreadyout(hreadyout),
  .hresp(hresp), .cpu_mask(cpu_mask), .cpu_ack(cpu_ack), .standby(standby), .int_req(int_req),
  .int_vector(int_vector), .mask_set(mask_set), .wake_up(wake_up));
`default_nettype wire
